// *** ssp_pkg.sv ***
package ssp_pkg;

   // Word indices of the registers on the plain register port.
   localparam logic [2:0] OFS_FLAGS = 3'h0;
   localparam logic [2:0] OFS_IEN   = 3'h1;
   localparam logic [2:0] OFS_PRIO  = 3'h2;
   localparam logic [2:0] OFS_RXCTL = 3'h3;
   localparam logic [2:0] OFS_TXBUF = 3'h4;
   localparam logic [2:0] OFS_TXCTL = 3'h5;
   localparam logic [2:0] OFS_BAUD  = 3'h6;
   localparam logic [2:0] OFS_RXBUF = 3'h7;

   // Bit positions shared by the flag, enable and priority registers.
   localparam int BIT_RX = 5;
   localparam int BIT_TX = 4;

   // Word lengths on the line, without and with the ninth bit.
   localparam logic [3:0] BITS_SHORT = 4'h8;
   localparam logic [3:0] BITS_LONG  = 4'h9;

   // Reset values of the stored registers.
   localparam logic [7:0] RXCTL_RESET = 8'h00;
   localparam logic [7:0] TXCTL_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET  = 8'h00;

   // Transmit status and control, bit 7 down to bit 0.
   typedef struct packed {
      logic clk_src;
      logic tx9;
      logic transmit_enable;
      logic sync;
      logic unused;
      logic high_baud_select;
      logic shifter_empty;
      logic ninth_send_bit;
   } ssp_txctl_t;

   // Receive status and control, bit 7 down to bit 0.
   typedef struct packed {
      logic port_en;
      logic rx9;
      logic single_en;
      logic cont_en;
      logic addr_det;
      logic framing_err;
      logic overrun_err;
      logic ninth_received_bit;
   } ssp_rxctl_t;

   // Transmit sequencer, one-hot.
   typedef enum logic [2:0] {
      TX_IDLE  = 3'h1,
      TX_LOAD  = 3'h2,
      TX_SHIFT = 3'h4
   } ssp_tx_state_t;

   // Receive sequencer, one-hot.
   typedef enum logic [2:0] {
      RX_IDLE  = 3'h1,
      RX_SHIFT = 3'h2,
      RX_DONE  = 3'h4
   } ssp_rx_state_t;

endpackage

// *** ssp_sync_port.sv ***
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps

// Function
// - Shifter reloads only after last bit leaves.
// - Buffer transfer takes one cycle, sets empty flag.
// - Empty flag cleared only by buffer write.
// - Transmit request forwarded only when enabled.
// - Shifter-empty status bit, read only, polled.
// - Continuous enable, or single in master mode, starts reception.
// - Receive data sampled on clock falling edge.
// - Single takes one word; continuous governs both.
// - Receive-complete flag and request on word.
// - Clearing continuous enable clears receive error.
// - Clock-source clear selects external shift clock.
// - Slave shifter keeps running in low power.
// - Sleep: second queued word waits, flag clear.
// - Second word loads later, then flag sets.
// - Transmit control layout, clock source at top.
// - Half duplex: transmit and receive exclude.
// - Enabled port pins become clock and data.
module ssp_sync_port #(
   parameter int DIV_WIDTH = 8
) (
   // Clock and reset.
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // Register port.
   input  wire logic [2:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // Low-power state of the surrounding core.
   input  wire logic       sleep_in,
   // Shift clock pin.
   input  wire logic       shift_clock_pin_in,
   output logic            shift_clock_pin_out,
   output logic            shift_clock_pin_oe_n_out,
   // Shift data pin.
   input  wire logic       shift_data_pin_in,
   output logic            shift_data_pin_out,
   output logic            shift_data_pin_oe_n_out,
   // Interrupt requests toward the core.
   output logic            tx_irq_out,
   output logic            rx_irq_out
);

   // The divisor must fit the eight-bit register word.
   if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin : g_chk
      $error("DIV_WIDTH must lie between 1 and 8");
   end

   // Stored registers.
   ssp_pkg::ssp_txctl_t    txctl_reg;          // Transmit control.
   ssp_pkg::ssp_rxctl_t    rxctl_reg;          // Receive control.
   logic                   tx_empty_flag_reg;  // Transmit buffer empty.
   logic                   rx_done_flag_reg;   // Word received.
   logic [1:0]             ien_reg;            // Receive, transmit enables.
   logic [1:0]             prio_reg;           // Priority bits, stored only.
   logic [7:0]             txbuf_reg;          // Transmit buffer.
   logic                   txbuf_full_reg;     // Buffer holds a word.
   logic [DIV_WIDTH-1:0]   baud_reg;           // Half-period divisor.
   logic [7:0]             rxbuf_reg;          // Receive buffer.
   // Shifters and sequencers.
   ssp_pkg::ssp_tx_state_t tx_st_reg, tx_st_next;
   ssp_pkg::ssp_rx_state_t rx_st_reg, rx_st_next;
   logic [8:0]             shifter_reg;        // Transmit shifter.
   logic [8:0]             rx_sh_reg;          // Receive shifter.
   logic [3:0]             bitcnt_reg;         // Bits moved so far.
   // Pin synchronisers and master clock.
   logic [2:0]             ck_s_reg;           // Clock pin sampling chain.
   logic [2:0]             dt_s_reg;           // Data pin sampling chain.
   logic                   ck_filt_reg;        // Agreed clock level.
   logic                   dt_filt_reg;        // Agreed data level.
   logic [DIV_WIDTH-1:0]   div_cnt_reg;        // Divider countdown.
   logic                   mclk_reg;           // Generated shift clock.
   // Output flops.
   logic [7:0]             rdata_reg;
   logic                   ck_oe_n_reg;
   logic                   dt_oe_n_reg;
   logic                   tx_irq_reg;
   logic                   rx_irq_reg;

   // Register decode.
   wire wr_txbuf = reg_wr_in & (reg_addr_in == ssp_pkg::OFS_TXBUF);
   wire wr_txctl = reg_wr_in & (reg_addr_in == ssp_pkg::OFS_TXCTL);
   wire wr_rxctl = reg_wr_in & (reg_addr_in == ssp_pkg::OFS_RXCTL);
   wire rd_rxbuf = reg_rd_in & (reg_addr_in == ssp_pkg::OFS_RXBUF);

   // Mode decode; the pins only serve when both bits are set.
   wire sync_on  = txctl_reg.sync & rxctl_reg.port_en;
   wire master   = txctl_reg.clk_src;
   wire tx_idle  = (tx_st_reg == ssp_pkg::TX_IDLE);
   wire tx_shift = (tx_st_reg == ssp_pkg::TX_SHIFT);
   wire rx_busy  = (rx_st_reg == ssp_pkg::RX_SHIFT);
   // The single enable does not count for a slave.
   wire rx_want  = rxctl_reg.cont_en | (rxctl_reg.single_en & master);

   // Master clock runs only while a word moves and the core is awake.
   wire gen_run  = sync_on & master & ~sleep_in & (tx_shift | rx_busy);
   wire div_tick = gen_run & (div_cnt_reg == '0);
   wire m_fall   = div_tick & mclk_reg;

   // A pin change counts once the second and third stages agree.
   wire ck_agree = (ck_s_reg[1] == ck_s_reg[2]);
   wire s_fall   = sync_on & ~master & ck_agree & ~ck_s_reg[2] & ck_filt_reg;
   wire sh_fall  = master ? m_fall : s_fall;

   // Word lengths and last-bit detection.
   wire [3:0] tx_bits = txctl_reg.tx9 ? ssp_pkg::BITS_LONG : ssp_pkg::BITS_SHORT;
   wire [3:0] rx_bits = rxctl_reg.rx9 ? ssp_pkg::BITS_LONG : ssp_pkg::BITS_SHORT;
   wire tx_last  = tx_shift & sh_fall & (bitcnt_reg == tx_bits - 4'h1);
   wire rx_last  = rx_busy & sh_fall & (bitcnt_reg == rx_bits - 4'h1);

   // A load needs enable, a waiting word and a quiet receiver.
   wire can_load = sync_on & txctl_reg.transmit_enable & txbuf_full_reg & ~rx_want & ~rx_busy;
   wire do_load  = (tx_st_next == ssp_pkg::TX_LOAD);
   wire rx_fin   = (rx_st_reg == ssp_pkg::RX_DONE);

   // Read data selection; unimplemented bits read as zero.
   wire ssp_pkg::ssp_txctl_t tx_view = '{clk_src: txctl_reg.clk_src, tx9: txctl_reg.tx9,
                                         transmit_enable: txctl_reg.transmit_enable, sync: txctl_reg.sync, unused: 1'b0,
                                         high_baud_select: txctl_reg.high_baud_select, shifter_empty: tx_idle,
                                         ninth_send_bit: txctl_reg.ninth_send_bit};
   wire [7:0] flag_view = {2'b00, rx_done_flag_reg, tx_empty_flag_reg, 4'h0};
   wire [7:0] rd_mux =
      (reg_addr_in == ssp_pkg::OFS_FLAGS) ? flag_view :
      (reg_addr_in == ssp_pkg::OFS_IEN)   ? {2'b00, ien_reg, 4'h0} :
      (reg_addr_in == ssp_pkg::OFS_PRIO)  ? {2'b00, prio_reg, 4'h0} :
      (reg_addr_in == ssp_pkg::OFS_RXCTL) ? {rxctl_reg[7:3], 1'b0, rxctl_reg[1:0]} :
      (reg_addr_in == ssp_pkg::OFS_TXBUF) ? txbuf_reg :
      (reg_addr_in == ssp_pkg::OFS_TXCTL) ? tx_view :
      (reg_addr_in == ssp_pkg::OFS_BAUD)  ? 8'(baud_reg) : rxbuf_reg;

   // Transmit sequencer: a word moves in only after the last bit left.
   always_comb begin
      tx_st_next = tx_st_reg;
      case (tx_st_reg)
         ssp_pkg::TX_IDLE: begin
            if (can_load) begin
               tx_st_next = ssp_pkg::TX_LOAD;
            end
         end
         // The transfer cycle itself; shifting starts after it.
         ssp_pkg::TX_LOAD: tx_st_next = ssp_pkg::TX_SHIFT;
         ssp_pkg::TX_SHIFT: begin
            if (tx_last) begin
               tx_st_next = can_load ? ssp_pkg::TX_LOAD : ssp_pkg::TX_IDLE;
            end
         end
         default: tx_st_next = ssp_pkg::TX_IDLE;
      endcase
   end

   // Receive sequencer: starts only while the transmitter is idle.
   always_comb begin
      rx_st_next = rx_st_reg;
      case (rx_st_reg)
         ssp_pkg::RX_IDLE: begin
            if (sync_on & rx_want & tx_idle & ~can_load) begin
               rx_st_next = ssp_pkg::RX_SHIFT;
            end
         end
         ssp_pkg::RX_SHIFT: begin
            if (!rx_want || !sync_on) begin
               rx_st_next = ssp_pkg::RX_IDLE;  // Dropped enable abandons the word.
            end else if (rx_last) begin
               rx_st_next = ssp_pkg::RX_DONE;
            end
         end
         ssp_pkg::RX_DONE: rx_st_next = ssp_pkg::RX_IDLE;
         default: rx_st_next = ssp_pkg::RX_IDLE;
      endcase
   end

   // Pin synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ck_s_reg    <= 3'h0;
         dt_s_reg    <= 3'h0;
         ck_filt_reg <= 1'b0;
         dt_filt_reg <= 1'b0;
      end else begin
         ck_s_reg    <= {ck_s_reg[1:0], shift_clock_pin_in};
         dt_s_reg    <= {dt_s_reg[1:0], shift_data_pin_in};
         ck_filt_reg <= ck_agree ? ck_s_reg[2] : ck_filt_reg;
         dt_filt_reg <= (dt_s_reg[1] == dt_s_reg[2]) ? dt_s_reg[2] : dt_filt_reg;
      end
   end

   // Master clock divider: each half period lasts divisor plus one cycles.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_cnt_reg <= '0;
         mclk_reg    <= 1'b0;
      end else begin
         div_cnt_reg <= (!gen_run || div_tick) ? baud_reg : div_cnt_reg - 1'b1;
         if (div_tick) begin
            mclk_reg <= ~mclk_reg;
         end else if (!(tx_shift || rx_busy)) begin
            mclk_reg <= 1'b0;  // Idle level low, so a word opens with a rise.
         end
      end
   end

   // Sequencers, shifters and the bit counter.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tx_st_reg   <= ssp_pkg::TX_IDLE;
         rx_st_reg   <= ssp_pkg::RX_IDLE;
         shifter_reg <= 9'h000;
         rx_sh_reg   <= 9'h000;
         bitcnt_reg  <= 4'h0;
      end else begin
         tx_st_reg <= tx_st_next;
         rx_st_reg <= rx_st_next;
         if (do_load) begin
            shifter_reg <= {txctl_reg.ninth_send_bit, txbuf_reg};
         end else if (tx_shift && sh_fall) begin
            shifter_reg <= {1'b0, shifter_reg[8:1]};
         end
         if (rx_busy && sh_fall) begin
            rx_sh_reg <= {dt_filt_reg, rx_sh_reg[8:1]};
         end
         if (do_load || rx_st_next != rx_st_reg) begin
            bitcnt_reg <= 4'h0;
         end else if (sh_fall && (tx_shift || rx_busy)) begin
            bitcnt_reg <= bitcnt_reg + 4'h1;
         end
      end
   end

   // Transmit buffer and its empty flag; a load beats a same-cycle write.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         txbuf_reg         <= 8'h00;
         txbuf_full_reg    <= 1'b0;
         tx_empty_flag_reg <= 1'b1;
      end else begin
         if (wr_txbuf) begin
            txbuf_reg <= reg_wdata_in;
         end
         txbuf_full_reg <= wr_txbuf | (txbuf_full_reg & ~do_load);
         if (do_load) begin
            tx_empty_flag_reg <= 1'b1;
         end else if (wr_txbuf) begin
            tx_empty_flag_reg <= 1'b0;
         end
      end
   end

   // Control registers, receive buffer and receive status.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         txctl_reg        <= ssp_pkg::TXCTL_RESET;
         rxctl_reg        <= ssp_pkg::RXCTL_RESET;
         baud_reg         <= DIV_WIDTH'(ssp_pkg::BAUD_RESET);
         ien_reg          <= 2'b00;
         prio_reg         <= 2'b00;
         rxbuf_reg        <= 8'h00;
         rx_done_flag_reg <= 1'b0;
      end else begin
         // Writable control bits; status bits stay with the hardware.
         if (wr_txctl) begin
            txctl_reg <= '{clk_src: reg_wdata_in[7], tx9: reg_wdata_in[6], transmit_enable: reg_wdata_in[5],
                           sync: reg_wdata_in[4], unused: 1'b0, high_baud_select: reg_wdata_in[2],
                           shifter_empty: 1'b0, ninth_send_bit: reg_wdata_in[0]};
         end
         if (reg_wr_in && reg_addr_in == ssp_pkg::OFS_BAUD) begin
            baud_reg <= reg_wdata_in[DIV_WIDTH-1:0];
         end
         if (reg_wr_in && reg_addr_in == ssp_pkg::OFS_IEN) begin
            ien_reg <= reg_wdata_in[ssp_pkg::BIT_RX:ssp_pkg::BIT_TX];
         end
         if (reg_wr_in && reg_addr_in == ssp_pkg::OFS_PRIO) begin
            prio_reg <= reg_wdata_in[ssp_pkg::BIT_RX:ssp_pkg::BIT_TX];
         end
         if (wr_rxctl) begin
            rxctl_reg[7:3] <= reg_wdata_in[7:3];
         end else if (rx_fin && !rxctl_reg.cont_en) begin
            rxctl_reg.single_en <= 1'b0;
         end
         // Overrun stands until the continuous enable is written low.
         if (rx_fin && rx_done_flag_reg) begin
            rxctl_reg.overrun_err <= 1'b1;
         end else if (wr_rxctl && !reg_wdata_in[4]) begin
            rxctl_reg.overrun_err <= 1'b0;
         end
         rxctl_reg.framing_err <= 1'b0;
         // A finished word lands in the buffer; set beats the read clear.
         if (rx_fin) begin
            rxbuf_reg     <= rxctl_reg.rx9 ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
            rxctl_reg.ninth_received_bit <= rxctl_reg.rx9 & rx_sh_reg[8];
            rx_done_flag_reg <= 1'b1;
         end else if (rd_rxbuf) begin
            rx_done_flag_reg <= 1'b0;
         end
      end
   end

   // Output flops: read data, pin enables and interrupt requests.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_reg   <= 8'h00;
         ck_oe_n_reg <= 1'b1;
         dt_oe_n_reg <= 1'b1;
         tx_irq_reg  <= 1'b0;
         rx_irq_reg  <= 1'b0;
      end else begin
         rdata_reg   <= reg_rd_in ? rd_mux : 8'h00;
         ck_oe_n_reg <= ~(sync_on & master);
         dt_oe_n_reg <= ~sync_on | (tx_st_next == ssp_pkg::TX_IDLE);
         tx_irq_reg  <= tx_empty_flag_reg & ien_reg[0];
         rx_irq_reg  <= rx_done_flag_reg & ien_reg[1];
      end
   end

   assign reg_rdata_out            = rdata_reg;
   assign shift_clock_pin_out      = mclk_reg;
   assign shift_clock_pin_oe_n_out = ck_oe_n_reg;
   assign shift_data_pin_out       = shifter_reg[0];
   assign shift_data_pin_oe_n_out  = dt_oe_n_reg;
   assign tx_irq_out               = tx_irq_reg;
   assign rx_irq_out               = rx_irq_reg;

   // Checks on the running behaviour.
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_load;
      tx_st_reg == ssp_pkg::TX_LOAD;
   endsequence
   sequence s_loaded;
      // A buffer write that lands in the load cycle itself queues the next word at once.
      ##1 (tx_st_reg == ssp_pkg::TX_SHIFT) && ((tx_empty_flag_reg && !txbuf_full_reg) || $past(wr_txbuf));
   endsequence

   property p_load_one_cycle;
      s_load |-> s_loaded;
   endproperty
   a_load_one_cycle: assert property (p_load_one_cycle) else $error("load not one cycle");

   property p_no_early_load;
      (tx_shift && !tx_last) |=> tx_st_reg != ssp_pkg::TX_LOAD;
   endproperty
   a_no_early_load: assert property (p_no_early_load) else $error("shifter reloaded early");

   property p_flag_clear_cause;
      $fell(tx_empty_flag_reg) |-> $past(wr_txbuf);
   endproperty
   a_flag_clear_cause: assert property (p_flag_clear_cause) else $error("flag cleared without write");

   property p_tx_irq_gate;
      tx_irq_out |-> $past(ien_reg[0]) && $past(tx_empty_flag_reg);
   endproperty
   a_tx_irq_gate: assert property (p_tx_irq_gate) else $error("transmit request not gated");

   property p_shifter_empty_busy;
      !tx_idle |-> !tx_view.shifter_empty;
   endproperty
   a_shifter_empty_busy: assert property (p_shifter_empty_busy) else $error("shifter empty while busy");

   property p_single_ends;
      (rx_fin && !rxctl_reg.cont_en && !wr_rxctl) |=> !rxctl_reg.single_en;
   endproperty
   a_single_ends: assert property (p_single_ends) else $error("single receive not ended");

   property p_rx_flag;
      rx_fin |=> rx_done_flag_reg ##1 (rx_irq_out == ien_reg[1] || $past(wr_rxctl));
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("receive flag missing");

   property p_half_duplex;
      !(tx_shift && rx_busy);
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("transmit and receive overlap");

   property p_err_clear;
      (wr_rxctl && !reg_wdata_in[4] && !rx_fin) |=> !rxctl_reg.overrun_err;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("overrun not cleared");

   property p_master_clock_drive;
      (sync_on && master) |=> !shift_clock_pin_oe_n_out;
   endproperty
   a_master_clock_drive: assert property (p_master_clock_drive) else $error("clock pin not driven");

endmodule

// *** ssp_far_end.sv ***
`timescale 1ns/100ps

// Far-end device: supplies the slave clock and words to receive, and captures what the port sends.
module ssp_far_end (
   // Levels seen on the shared wires.
   input  wire logic       line_clk_in,
   input  wire logic       line_dt_oe_n_in,
   input  wire logic       line_dt_in,
   // Lines this party drives.
   output logic            far_clk_out,
   output logic            far_dt_out,
   // Last captured word and the number captured.
   output logic      [7:0] got_word_out,
   output logic      [7:0] got_cnt_out
);
   logic [7:0]  shift_reg;  // Captured bits, LSB first.
   logic [15:0] send_reg;   // Bits still queued for the port.
   int          nbit;       // Bits gathered in the current word.
   int          nsend;      // Bits left to supply.

   initial begin
      far_clk_out = 1'b0;
      far_dt_out = 1'b1;
      got_word_out = 8'h00;
      got_cnt_out = 8'h00;
      nbit = 0;
      nsend = 0;
   end

   // Sample on the rise, half a period away from the edge where the port moves its data.
   always @(posedge line_clk_in) begin
      if (!line_dt_oe_n_in) begin
         shift_reg = {line_dt_in, shift_reg[7:1]};
         nbit++;
         if (nbit == 8) begin
            got_word_out = shift_reg;
            nbit = 0;
            got_cnt_out++;
         end
      end else if (nsend > 0) begin
         far_dt_out = send_reg[0];
         send_reg = send_reg >> 1;
         nsend--;
      end
   end

   // Once the last bit has been held past its fall, the line no longer shows it.
   always @(negedge line_clk_in) begin
      if (nsend == 0 && line_dt_oe_n_in) begin
         #100 far_dt_out = ~far_dt_out;
      end
   end

   // Queue bits for the port to receive, first bit in bit 0.
   task automatic supply(input logic [15:0] w, input int n);
      send_reg = w;
      nsend = n;
   endtask

   // A slave-mode frame; the clock stands still low outside it.
   task automatic frame(input int n);
      repeat (n) begin
         #80 far_clk_out = 1'b1;
         #80 far_clk_out = 1'b0;
      end
   endtask
endmodule

// *** ssp_sync_port_bench.sv ***
`timescale 1ns/100ps

// Self-checking bench: register traffic plus master and slave serial transfers.
module ssp_sync_port_bench;
   logic       clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic [2:0] reg_addr_in = 3'h0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic       reg_wr_in = 1'b0;
   logic       reg_rd_in = 1'b0;
   logic       sleep_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic       ck_out, ck_oe_n, dt_out, dt_oe_n, tx_irq_out, rx_irq_out;
   logic       far_clk, far_dt;
   logic [7:0] got_word, got_cnt;
   wire        clk_wire = !ck_oe_n ? ck_out : far_clk;  // Whoever is enabled owns the wire.
   wire        dt_wire  = !dt_oe_n ? dt_out : far_dt;
   logic [7:0] exp_q[$];                                // Words expected at the far end.
   logic [7:0] w[0:7];                                  // Random payloads.
   int         n_fail = 0;
   int         samples_checked = 0;
   int         seed = 98674;

   always #10 clk_in = ~clk_in;

   ssp_sync_port ssp_sync_port_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .sleep_in(sleep_in), .shift_clock_pin_in(clk_wire), .shift_clock_pin_out(ck_out),
      .shift_clock_pin_oe_n_out(ck_oe_n), .shift_data_pin_in(dt_wire), .shift_data_pin_out(dt_out),
      .shift_data_pin_oe_n_out(dt_oe_n), .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));

   ssp_far_end ssp_far_end_i (.line_clk_in(clk_wire), .line_dt_oe_n_in(dt_oe_n), .line_dt_in(dt_wire),
      .far_clk_out(far_clk), .far_dt_out(far_dt), .got_word_out(got_word), .got_cnt_out(got_cnt));

   // Compare one result and count it.
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   // One-cycle register read; data is looked at in the cycle after the strobe.
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 check(reg_rdata_out, exp);
   endtask

   // Bounded wait for the receive request.
   task automatic wait_rx;
      // The request lags the buffer read by a cycle, so let the old level drain first.
      repeat (2) @(posedge clk_in);
      for (int i = 0; i < 1000 && rx_irq_out !== 1'b1; i++) @(posedge clk_in);
      check({7'h00, rx_irq_out}, 8'h01);
   endtask

   // Every captured word must be the next one written.
   always @(got_cnt) if (got_cnt != 8'h00) check(got_word, exp_q.pop_front());

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // The whole run needs about a thousand cycles; twenty thousand means a hang.
   initial begin
      #400000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      foreach (w[i]) w[i] = $random(seed);
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rd(ssp_pkg::OFS_FLAGS, 8'h10);
      rd(ssp_pkg::OFS_TXCTL, 8'h02);
      wr(ssp_pkg::OFS_FLAGS, 8'h00);
      rd(ssp_pkg::OFS_FLAGS, 8'h10);
      wr(ssp_pkg::OFS_TXCTL, 8'h0E);
      rd(ssp_pkg::OFS_TXCTL, 8'h06);
      wr(ssp_pkg::OFS_PRIO, 8'h30);
      rd(ssp_pkg::OFS_PRIO, 8'h30);
      // Master transmit of two back-to-back words.
      wr(ssp_pkg::OFS_BAUD, 8'h07);
      wr(ssp_pkg::OFS_RXCTL, 8'h80);
      wr(ssp_pkg::OFS_TXCTL, 8'hB1);
      wr(ssp_pkg::OFS_IEN, 8'h10);
      repeat (2) @(posedge clk_in);
      check({7'h00, tx_irq_out}, 8'h01);
      exp_q.push_back(w[0]);
      exp_q.push_back(w[1]);
      wr(ssp_pkg::OFS_TXBUF, w[0]);
      wr(ssp_pkg::OFS_TXBUF, w[1]);
      rd(ssp_pkg::OFS_FLAGS, 8'h00);
      check({7'h00, ck_oe_n}, 8'h00);
      for (int i = 0; i < 1000 && got_cnt !== 8'h02; i++) @(posedge clk_in);
      repeat (20) @(posedge clk_in);
      rd(ssp_pkg::OFS_TXCTL, 8'hB3);
      rd(ssp_pkg::OFS_FLAGS, 8'h10);
      wr(ssp_pkg::OFS_IEN, 8'h00);
      repeat (2) @(posedge clk_in);
      check({7'h00, tx_irq_out}, 8'h00);
      // Master single receive, then continuous with both enables set.
      wr(ssp_pkg::OFS_TXCTL, 8'h90);
      wr(ssp_pkg::OFS_IEN, 8'h20);
      ssp_far_end_i.supply({8'h00, w[2]}, 8);
      wr(ssp_pkg::OFS_RXCTL, 8'hA0);
      wait_rx();
      rd(ssp_pkg::OFS_RXCTL, 8'h80);
      rd(ssp_pkg::OFS_RXBUF, w[2]);
      rd(ssp_pkg::OFS_FLAGS, 8'h10);
      ssp_far_end_i.supply({w[4], w[3]}, 16);
      wr(ssp_pkg::OFS_RXCTL, 8'hB0);
      wait_rx();
      rd(ssp_pkg::OFS_RXBUF, w[3]);
      wait_rx();
      rd(ssp_pkg::OFS_RXBUF, w[4]);
      wr(ssp_pkg::OFS_RXCTL, 8'h80);
      rd(ssp_pkg::OFS_RXCTL, 8'h80);
      // Slave transmit of two queued words while asleep.
      wr(ssp_pkg::OFS_TXCTL, 8'h30);
      wr(ssp_pkg::OFS_IEN, 8'h10);
      exp_q.push_back(w[5]);
      exp_q.push_back(w[6]);
      wr(ssp_pkg::OFS_TXBUF, w[5]);
      wr(ssp_pkg::OFS_TXBUF, w[6]);
      sleep_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      check({7'h00, ck_oe_n}, 8'h01);
      rd(ssp_pkg::OFS_FLAGS, 8'h00);
      ssp_far_end_i.frame(8);
      repeat (10) @(posedge clk_in);
      rd(ssp_pkg::OFS_FLAGS, 8'h10);
      check({7'h00, tx_irq_out}, 8'h01);
      ssp_far_end_i.frame(8);
      repeat (10) @(posedge clk_in);
      check(got_cnt, 8'h04);
      report_and_stop();
   end
endmodule
